// ===== bench/csl_node_model.sv
// Purpose: Far side frame engine: bus gaps, transmit outcome, stamps
// Assumes: One transmission at a time
// Notes: quiet holds off bus gaps, slow lengthens frames
`timescale 1ns/1ps
`default_nettype none
module csl_node_model (
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire logic TX_START,
    input wire logic TX_BUSY,
    input wire logic quiet,
    input wire logic slow,
    input wire logic fail_req,
    output logic INTERMISSION,
    output logic TX_DONE,
    output logic TX_FAIL,
    output logic [15:0] TS_COUNT
);
    logic [4:0] left;
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            TS_COUNT <= '0;
            INTERMISSION <= 1'b0;
        end else begin
            TS_COUNT <= TS_COUNT + 16'h1;
            INTERMISSION <= !quiet && !TX_BUSY && TS_COUNT[1:0] == 2'h0;
        end
    end
    // Frame length counted from start; outcome on the last cycle
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            left <= '0;
            TX_DONE <= 1'b0;
            TX_FAIL <= 1'b0;
        end else begin
            left <= TX_START ? (slow ? 5'h14 : 5'h3) : left - 5'(left != 0);
            TX_DONE <= left == 5'h1 && !fail_req;
            TX_FAIL <= left == 5'h1 && fail_req;
        end
    end
endmodule
`default_nettype wire

// ===== bench/csl_slot_ctl_sva.sv
// Purpose: Port checks for the slot control block
// Assumes: One clock, RST_B low resets
// Notes: Bound from tb
`timescale 1ns/1ps
`default_nettype none
module csl_slot_ctl_sva (
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire logic REG_RD,
    input wire logic [31:0] REG_RDATA,
    input wire logic INTERMISSION,
    input wire logic TX_DONE,
    input wire logic TX_FAIL,
    input wire logic TX_START,
    input wire logic TX_BUSY,
    input wire logic [3:0] TX_SLOT,
    input wire logic TX_REMOTE
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_B);
    a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == '0)
        else $error("read data outside slot");
    a_start_cause: assert property (TX_START |->
        $past(INTERMISSION) && !$past(TX_BUSY)) else $error("start uncaused");
    a_start_pulse: assert property (TX_START |=> !TX_START)
        else $error("start too long");
    a_start_busy: assert property (TX_START |-> TX_BUSY)
        else $error("start without busy");
    a_busy_rise: assert property ($rose(TX_BUSY) |-> TX_START)
        else $error("busy without start");
    a_busy_end: assert property (TX_BUSY && (TX_DONE || TX_FAIL) |=>
        !TX_BUSY) else $error("busy after end");
    a_busy_hold: assert property (TX_BUSY && !TX_DONE && !TX_FAIL |=>
        TX_BUSY) else $error("busy dropped");
    a_tx_stable: assert property (!TX_START |->
        $stable({TX_SLOT, TX_REMOTE})) else $error("tx fields moved");
    cover property (TX_START && TX_REMOTE);
endmodule
`default_nettype wire

// ===== bench/tb.sv
// Purpose: Self-checking bench for the slot control block
// Assumes: Node model drives the transmit side
// Notes: A monitor checks reads and starts against queued notes
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
    $display("Error %0t: got %h exp %h", $time, g, e); end end
module tb;
    import csl_pkg::*;
    logic CORE_CLK = 1'b0;
    logic RST_B = 1'b0;
    logic REG_WR = 1'b0, REG_RD = 1'b0, RX_DONE = 1'b0, RX_EXT = 1'b0;
    logic RX_REMOTE = 1'b0, quiet = 1'b1, slow = 1'b0, fail_req = 1'b0;
    logic rd_d = 1'b0, TX_START, TX_BUSY, TX_REMOTE, TX_EXT, TX_DONE;
    logic TX_FAIL, INTERMISSION, SLOT_IRQ;
    logic [ADDR_W-1:0] REG_ADDR = '0;
    logic [DATA_W-1:0] REG_WDATA = '0, REG_RDATA, got, e;
    logic [ID_W-1:0] RX_ID = '0, TX_ID, ida, idb;
    logic [3:0] RX_DLC = '0, TX_DLC, TX_SLOT;
    logic [63:0] RX_DATA = '0, dat;
    logic [15:0] TS_COUNT, ts;
    logic [8:0] t;
    logic [31:0] ex_q[$], mk_q[$];
    logic [8:0] tx_q[$];
    int failures = 0, n_compared = 0, cycles = 0;
    csl_slot_ctl csl_slot_ctl_inst (.CORE_CLK, .RST_B, .REG_ADDR, .REG_WDATA,
        .REG_WR, .REG_RD, .REG_RDATA, .RX_DONE, .RX_ID, .RX_EXT, .RX_REMOTE,
        .RX_DLC, .RX_DATA, .TS_COUNT, .INTERMISSION, .TX_DONE, .TX_FAIL,
        .TX_START, .TX_SLOT, .TX_REMOTE, .TX_ID, .TX_EXT, .TX_DLC, .TX_BUSY,
        .SLOT_IRQ);
    csl_node_model csl_node_model_inst (.CORE_CLK, .RST_B, .TX_START,
        .TX_BUSY, .quiet, .slow, .fail_req, .INTERMISSION, .TX_DONE,
        .TX_FAIL, .TS_COUNT);
    initial begin
        forever #5 CORE_CLK = ~CORE_CLK;
    end
    task automatic complete_run();
        $display("Compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge CORE_CLK) begin
        rd_d <= REG_RD;
        if (rd_d) begin
            e = ex_q.pop_front();
            got = REG_RDATA & mk_q.pop_front();
            `CHK(got, e)
        end
        if (TX_START) begin
            t = tx_q.size() > 0 ? tx_q.pop_front() : 'x;
            `CHK({TX_DLC, TX_REMOTE, TX_SLOT}, t)
            `CHK({TX_EXT, TX_ID[28:18]}, {1'b0, idb[28:18]})
        end
        cycles++;
        if (cycles == 4000) begin
            $display("Error %0t: timeout", $time);
            failures++;
            complete_run();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CORE_CLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge CORE_CLK);
        REG_WR <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, m);
        @(posedge CORE_CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        ex_q.push_back(x & m);
        mk_q.push_back(m);
        @(posedge CORE_CLK);
        REG_RD <= 1'b0;
    endtask
    task automatic frame(input logic [ID_W-1:0] id, input logic ext, rem);
        @(posedge CORE_CLK);
        dat = {$urandom, $urandom};
        RX_ID <= id | {11'h0, 18'($urandom)};
        RX_EXT <= ext;
        RX_REMOTE <= rem;
        RX_DLC <= 4'h8;
        RX_DATA <= dat;
        RX_DONE <= 1'b1;
        @(posedge CORE_CLK);
        ts = TS_COUNT;
        RX_DONE <= 1'b0;
        RX_ID <= ~RX_ID;
        RX_DATA <= ~dat;
        repeat (6) @(posedge CORE_CLK);
    endtask
    // Opens bus gaps until queued starts are seen, then any stray start fails
    task automatic go_tx();
        quiet <= 1'b0;
        for (int i = 0; i < 300 && (tx_q.size() > 0 || TX_BUSY); i++) begin
            @(posedge CORE_CLK);
        end
        repeat (12) @(posedge CORE_CLK);
        quiet <= 1'b1;
        @(posedge CORE_CLK);
    endtask
    initial begin
        void'($urandom(32'h9E6B82C4));
        repeat (2) @(posedge CORE_CLK);
        RST_B <= 1'b1;
        ida = {11'($urandom), 18'h0};
        idb = ~ida & 29'h1FFC0000;
        wr(ADR_IER, 32'hFFFF);
        wr(8'h48, ida);
        wr(8'h54, ida);
        wr(8'h02, 32'h4E);
        wr(8'h05, 32'h40);
        frame(ida, 1'b0, 1'b0);
        rd(8'h02, 32'h41, 32'hEF);
        rd(8'h05, 32'h40, 32'hEF);
        rd(ADR_ISR, 32'h4, 32'hFFFF);
        `CHK(SLOT_IRQ, 1'b1)
        rd(8'h48, {3'h0, ida}, 32'h1FFC0000);
        rd(8'h49, dat[31:0], 32'hFFFFFFFF);
        rd(8'h4A, dat[63:32], 32'hFFFFFFFF);
        rd(8'h4B, {ts, 16'h8}, 32'hFFFF000F);
        frame(ida, 1'b0, 1'b0);
        rd(8'h02, 32'h43, 32'hEF);
        wr(8'h02, 32'h4E);
        rd(8'h02, 32'h42, 32'hEF);
        wr(8'h02, 32'h40);
        frame(ida, 1'b0, 1'b0);
        frame(ida, 1'b0, 1'b0);
        rd(8'h02, 32'h41, 32'hEF);
        wr(8'h02, 32'h00);
        frame(ida, 1'b0, 1'b0);
        rd(8'h02, 32'h00, 32'hEF);
        rd(8'h05, 32'h41, 32'hEF);
        wr(8'h05, 32'h40);
        wr(ADR_ISR, 32'hFFFF);
        frame(idb, 1'b0, 1'b0);
        frame(ida, 1'b1, 1'b0);
        frame(ida, 1'b0, 1'b1);
        rd(ADR_ISR, 32'h0, 32'hFFFF);
        `CHK(SLOT_IRQ, 1'b0)
        wr(ADR_MASK, {3'h0, ~29'h40000});
        frame(ida ^ 29'h40000, 1'b0, 1'b0);
        rd(8'h05, 32'h41, 32'hEF);
        wr(ADR_MODE, 32'h1);
        wr(8'h78, idb);
        wr(8'h0E, 32'h40);
        frame(idb, 1'b0, 1'b1);
        rd(8'h0E, 32'h41, 32'hEF);
        wr(8'h03, 32'h00);
        rd(8'h03, 32'h00, 32'h08);
        wr(8'h4C, idb);
        wr(8'h5C, idb);
        wr(8'h4F, 32'h5);
        wr(8'h5F, 32'h5);
        wr(8'h0F, 32'hA0);
        wr(8'h07, 32'hA0);
        wr(8'h03, 32'hA0);
        rd(8'h03, 32'hA4, 32'hEF);
        wr(ADR_ISR, 32'hFFFF);
        tx_q = '{9'h0B3, 9'h0B7};
        slow <= 1'b1;
        go_tx();
        rd(8'h03, 32'h40, 32'hCD);
        rd(ADR_ISR, 32'h88, 32'hFFFF);
        frame(idb, 1'b0, 1'b0);
        rd(8'h03, 32'h41, 32'hCD);
        wr(8'h03, 32'h00);
        wr(8'h07, 32'hA0);
        frame(idb, 1'b0, 1'b0);
        rd(8'h07, 32'h01, 32'h81);
        go_tx();
        wr(8'h07, 32'hAE);
        rd(8'h07, 32'h60, 32'hE5);
        tx_q.push_back(9'h117);
        wr(8'h07, 32'hA0);
        go_tx();
        fail_req <= 1'b1;
        slow <= 1'b0;
        tx_q.push_back(9'h117);
        wr(8'h07, 32'hA0);
        quiet <= 1'b0;
        for (int i = 0; i < 50 && !TX_START; i++) begin
            @(posedge CORE_CLK);
        end
        quiet <= 1'b1;
        repeat (8) @(posedge CORE_CLK);
        rd(8'h07, 32'h80, 32'h88);
        wr(8'h07, 32'h0F);
        rd(8'h07, 32'h00, 32'h88);
        repeat (2) @(posedge CORE_CLK);
        `CHK(tx_q.size(), 0)
        complete_run();
    end
endmodule
bind csl_slot_ctl csl_slot_ctl_sva csl_slot_ctl_sva_inst (.CORE_CLK, .RST_B,
    .REG_RD, .REG_RDATA, .INTERMISSION, .TX_DONE, .TX_FAIL, .TX_START,
    .TX_BUSY, .TX_SLOT, .TX_REMOTE);
`default_nettype wire

// ===== common/csl_frame_if.sv
// Purpose: Carries the header of the frame under acceptance test.
// Assumes: Driven by the slot controller, read by each slot filter.
// Notes:   Plain wires, no clocking.
`timescale 1ns/1ps
`default_nettype none
interface csl_frame_if;
    logic [csl_pkg::ID_W-1:0] id;
    logic ext;
    logic remote;
    modport src (output id, ext, remote);
    modport snk (input id, ext, remote);
endinterface
`default_nettype wire

// ===== common/csl_pkg.sv
// Purpose: Shared constants and types for the CAN slot receive and
//          remote transmit control block.
// Assumes: One clock, sixteen slots, 29-bit identifiers.
// Notes:   Standard identifiers sit in the top 11 identifier bits.
`default_nettype none
package csl_pkg;
    localparam int NUM_SLOTS = 16;
    localparam int SLOT_IW = 4;
    localparam int ID_W = 29;
    localparam int ID_STD_LSB = 18;
    localparam int DLC_W = 4;
    localparam int TS_W = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CTL_W = 8;
    // Slots that change role in shared slot mode
    localparam int SHARED_LO = 14;
    // Register map, word addresses on the register port, one 32-bit register each
    localparam logic [3:0] ADR_CTL_PAGE = 4'h0;
    localparam logic [7:0] ADR_ISR = 8'h10;
    localparam logic [7:0] ADR_IER = 8'h11;
    localparam logic [7:0] ADR_MODE = 8'h12;
    localparam logic [7:0] ADR_MASK = 8'h13;
    localparam logic [7:0] ADR_EXT = 8'h14;
    localparam logic [1:0] ADR_MSG_PAGE = 2'h1;
    localparam logic [1:0] MSG_ID = 2'h0;
    localparam logic [1:0] MSG_DLO = 2'h1;
    localparam logic [1:0] MSG_DHI = 2'h2;
    localparam logic [1:0] MSG_TSD = 2'h3;
    localparam int MSG_TS_LSB = 16;
    localparam int MODE_SHARED = 0;
    // Control register values with a defined meaning
    localparam logic [7:0] CTL_STOP = 8'h00;
    localparam logic [7:0] CTL_RX_OV = 8'h4E;
    localparam logic [7:0] CTL_RX = 8'h40;
    localparam logic [7:0] CTL_RMT_TX = 8'hA0;
    localparam logic [7:0] CTL_RMT_RX = 8'hAE;
    localparam logic [7:0] CTL_ABORT = 8'h0F;
    // Control register bit positions
    localparam int CB_TR = 7;
    localparam int CB_RR = 6;
    localparam int CB_RM = 5;
    localparam int CB_ACT = 3;
    localparam int CB_RA = 2;
    localparam int CB_OVF = 1;
    localparam int CB_OVEN = 1;
    localparam int CB_DONE = 0;
    // Reset values
    localparam logic [ID_W-1:0] MASK_RST = 29'h1FFFFFFF;
    localparam logic [15:0] EXT_RST = 16'h0000;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_MATCH = 2'b01,
        RX_STORE = 2'b10,
        RX_FIN = 2'b11
    } csl_rx_state_t;
endpackage
`default_nettype wire

// ===== hdl/csl_filter.sv
// Purpose: Acceptance test of one slot against the frame under test.
// Assumes: Mask bit 1 compares, mask bit 0 ignores.
// Notes:   Purely combinational.
`timescale 1ns/1ps
`default_nettype none
module csl_filter (
    csl_frame_if.snk frm,
    input wire logic [csl_pkg::ID_W-1:0] slot_id,
    input wire logic slot_ext,
    input wire logic [csl_pkg::ID_W-1:0] mask,
    input wire logic armed,
    input wire logic take_remote,
    output logic match
);
    import csl_pkg::*;
    logic [ID_W-1:0] eff_mask;
    logic type_ok;
    // Standard frames compare only the upper identifier bits
    assign eff_mask = frm.ext ? mask :
        {mask[ID_W-1:ID_STD_LSB], {ID_STD_LSB{1'b0}}};
    assign type_ok = frm.remote ? take_remote : 1'b1;
    assign match = armed && type_ok && (slot_ext == frm.ext) &&
        (((frm.id ^ slot_id) & eff_mask) == '0);
endmodule
`default_nettype wire

// ===== hdl/csl_prio.sv
// Purpose: Picks the lowest-numbered asserted request.
// Assumes: IW wide enough to number N requests.
// Notes:   Combinational.
`timescale 1ns/1ps
`default_nettype none
module csl_prio #(
    parameter int N = 16,
    parameter int IW = 4
) (
    input wire logic [N-1:0] req,
    output logic valid,
    output logic [IW-1:0] idx
);
    if ((1 << IW) < N) begin : g_chk
        $error("csl_prio: IW too narrow for N");
    end
    always_comb begin
        valid = 1'b0;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                valid = 1'b1;
                idx = IW'(i);
            end
        end
    end
endmodule
`default_nettype wire

// ===== hdl/csl_slot_ctl.sv
// Purpose: Slot control of a sixteen-slot CAN controller: receive
//          filtering and storage, remote request transmit selection.
// Assumes: Frame engine on CORE_CLK gives one-cycle strobes.
// Notes:   Slot contents carry no reset.
`timescale 1ns/1ps
`default_nettype none
module csl_slot_ctl #(
    parameter int TSW = csl_pkg::TS_W
) (
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire logic [csl_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic [csl_pkg::DATA_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [csl_pkg::DATA_W-1:0] REG_RDATA,
    input wire logic RX_DONE,
    input wire logic [csl_pkg::ID_W-1:0] RX_ID,
    input wire logic RX_EXT,
    input wire logic RX_REMOTE,
    input wire logic [csl_pkg::DLC_W-1:0] RX_DLC,
    input wire logic [63:0] RX_DATA,
    input wire logic [TSW-1:0] TS_COUNT,
    input wire logic INTERMISSION,
    input wire logic TX_DONE,
    input wire logic TX_FAIL,
    output logic TX_START,
    output logic [csl_pkg::SLOT_IW-1:0] TX_SLOT,
    output logic TX_REMOTE,
    output logic [csl_pkg::ID_W-1:0] TX_ID,
    output logic TX_EXT,
    output logic [csl_pkg::DLC_W-1:0] TX_DLC,
    output logic TX_BUSY,
    output logic SLOT_IRQ
);
    import csl_pkg::*;

    if (TSW < 1 || TSW > 16) begin : g_chk
        $error("csl_slot_ctl: time stamp width must be 1 to 16");
    end

    localparam int NS = NUM_SLOTS;

    // Per-slot control state, then the shared mode flag and acceptance mask
    logic [NS-1:0] tr;
    logic [NS-1:0] rr;
    logic [NS-1:0] rm;
    logic [NS-1:0] ra;
    logic [NS-1:0] act;
    logic [NS-1:0] done;
    logic [NS-1:0] ovf;
    logic [NS-1:0] oven;
    logic [NS-1:0] abort_req;
    logic [NS-1:0] isr;
    logic [NS-1:0] ier;
    logic [NS-1:0] ext_sel;
    logic shared_mode;
    logic [ID_W-1:0] mask;

    // Slot storage
    logic [ID_W-1:0] slot_id [NS];
    logic [DLC_W-1:0] slot_dlc [NS];
    logic [31:0] slot_dlo [NS];
    logic [31:0] slot_dhi [NS];
    logic [TSW-1:0] slot_ts [NS];

    // Frame capture and search
    csl_rx_state_t rx_state;
    logic [ID_W-1:0] cap_id;
    logic cap_ext;
    logic cap_remote;
    logic [DLC_W-1:0] cap_dlc;
    logic [63:0] cap_data;
    logic [TSW-1:0] cap_ts;
    logic [SLOT_IW-1:0] rx_slot;
    logic [NS-1:0] match;
    logic [NS-1:0] armed;
    logic [NS-1:0] take_remote;
    logic rx_hit;
    logic [SLOT_IW-1:0] rx_pick;

    // Transmit selection
    logic [NS-1:0] tx_req;
    logic tx_any;
    logic [SLOT_IW-1:0] tx_pick;
    logic tx_go;
    logic tx_end;

    // Register port decode
    logic ctl_wr;
    logic msg_wr;
    logic [SLOT_IW-1:0] wr_slot;
    logic [SLOT_IW-1:0] msg_slot;
    logic [1:0] msg_fld;
    logic [CTL_W-1:0] wbyte;
    logic [DATA_W-1:0] next_rdata;

    assign ctl_wr = REG_WR && (REG_ADDR[7:4] == ADR_CTL_PAGE);
    assign msg_wr = REG_WR && (REG_ADDR[7:6] == ADR_MSG_PAGE);
    assign wr_slot = REG_ADDR[3:0];
    assign msg_slot = REG_ADDR[5:2];
    assign msg_fld = REG_ADDR[1:0];
    assign wbyte = REG_WDATA[CTL_W-1:0];

    csl_frame_if frm ();
    assign frm.id = cap_id;
    assign frm.ext = cap_ext;
    assign frm.remote = cap_remote;

    for (genvar g = 0; g < NS; g++) begin : g_slot
        localparam bit IS_SHARED = (g >= SHARED_LO);
        // A slot waiting to send a remote request still takes data
        assign armed[g] = (rr[g] || (ra[g] && tr[g])) &&
            !(TX_BUSY && (TX_SLOT == SLOT_IW'(g)));
        assign take_remote[g] = shared_mode && IS_SHARED && rr[g];
        // A slot being matched right now must not start sending
        assign tx_req[g] = tr[g] && !act[g] &&
            !(rx_state == RX_MATCH && rx_hit && rx_pick == SLOT_IW'(g)) &&
            !(shared_mode && IS_SHARED);
        csl_filter u_filter (
            .frm(frm.snk),
            .slot_id(slot_id[g]),
            .slot_ext(ext_sel[g]),
            .mask(mask),
            .armed(armed[g]),
            .take_remote(take_remote[g]),
            .match(match[g])
        );
    end

    csl_prio #(.N(NS), .IW(SLOT_IW)) u_rx_prio (
        .req(match),
        .valid(rx_hit),
        .idx(rx_pick)
    );

    csl_prio #(.N(NS), .IW(SLOT_IW)) u_tx_prio (
        .req(tx_req),
        .valid(tx_any),
        .idx(tx_pick)
    );

    assign tx_go = INTERMISSION && !TX_BUSY && tx_any;
    assign tx_end = TX_BUSY && (TX_DONE || TX_FAIL);

    // Receive sequencer: capture, filter, store, finish
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rx_state <= RX_IDLE;
            rx_slot <= '0;
        end else begin
            unique case (rx_state)
                RX_IDLE: begin
                    if (RX_DONE) begin
                        rx_state <= RX_MATCH;
                    end
                end
                RX_MATCH: begin
                    if (rx_hit) begin
                        rx_slot <= rx_pick;
                        rx_state <= RX_STORE;
                    end else begin
                        rx_state <= RX_IDLE;
                    end
                end
                RX_STORE: begin
                    rx_state <= RX_FIN;
                end
                RX_FIN: begin
                    rx_state <= RX_IDLE;
                end
            endcase
        end
    end

    // Frame and time stamp capture at end of reception
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            cap_id <= '0;
            cap_ext <= 1'b0;
            cap_remote <= 1'b0;
            cap_dlc <= '0;
            cap_data <= '0;
            cap_ts <= '0;
        end else if (RX_DONE && rx_state == RX_IDLE) begin
            cap_id <= RX_ID;
            cap_ext <= RX_EXT;
            cap_remote <= RX_REMOTE;
            cap_dlc <= RX_DLC;
            cap_data <= RX_DATA;
            cap_ts <= TS_COUNT;
        end
    end

    // Slot control flags; hardware updates come last and win
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            tr <= '0;
            rr <= '0;
            rm <= '0;
            ra <= '0;
            act <= '0;
            done <= '0;
            ovf <= '0;
            oven <= '0;
            abort_req <= '0;
        end else begin
            if (ctl_wr) begin
                if (wbyte == CTL_ABORT) begin
                    if (act[wr_slot]) begin
                        abort_req[wr_slot] <= 1'b1;
                    end else begin
                        tr[wr_slot] <= 1'b0;
                    end
                end else begin
                    done[wr_slot] <= 1'b0;
                    if (!wbyte[CB_OVEN]) begin
                        ovf[wr_slot] <= 1'b0;
                    end
                    if (wbyte == CTL_RMT_RX) begin
                        tr[wr_slot] <= 1'b0;
                        rr[wr_slot] <= 1'b1;
                        rm[wr_slot] <= 1'b1;
                        ra[wr_slot] <= 1'b0;
                        oven[wr_slot] <= 1'b1;
                    end else begin
                        tr[wr_slot] <= wbyte[CB_TR];
                        rr[wr_slot] <= wbyte[CB_RR];
                        rm[wr_slot] <= wbyte[CB_RM];
                        ra[wr_slot] <= (wbyte == CTL_RMT_TX);
                        oven[wr_slot] <= wbyte[CB_OVEN] && wbyte[CB_RR];
                    end
                end
            end
            if (tx_go) begin
                act[tx_pick] <= 1'b1;
            end
            if (tx_end) begin
                act[TX_SLOT] <= 1'b0;
                abort_req[TX_SLOT] <= 1'b0;
                if (TX_DONE || abort_req[TX_SLOT] || (ctl_wr &&
                    wbyte == CTL_ABORT && wr_slot == TX_SLOT)) begin
                    tr[TX_SLOT] <= 1'b0;
                end
                if (TX_DONE && ra[TX_SLOT]) begin
                    ra[TX_SLOT] <= 1'b0;
                    rr[TX_SLOT] <= 1'b1;
                end else if (TX_DONE) begin
                    done[TX_SLOT] <= 1'b1;
                end
            end
            if (rx_state == RX_MATCH && rx_hit) begin
                act[rx_pick] <= 1'b1;
            end
            if (rx_state == RX_STORE) begin
                done[rx_slot] <= 1'b1;
                if (done[rx_slot] && oven[rx_slot]) begin
                    ovf[rx_slot] <= 1'b1;
                end
                if (ra[rx_slot] && tr[rx_slot]) begin
                    tr[rx_slot] <= 1'b0;
                    ra[rx_slot] <= 1'b0;
                    rr[rx_slot] <= 1'b1;
                end
            end
            if (rx_state == RX_FIN) begin
                act[rx_slot] <= 1'b0;
            end
        end
    end

    // Slot contents; a received frame beats a software write
    always_ff @(posedge CORE_CLK) begin
        if (msg_wr) begin
            unique case (msg_fld)
                MSG_ID: slot_id[msg_slot] <= REG_WDATA[ID_W-1:0];
                MSG_DLO: slot_dlo[msg_slot] <= REG_WDATA;
                MSG_DHI: slot_dhi[msg_slot] <= REG_WDATA;
                MSG_TSD: slot_dlc[msg_slot] <= REG_WDATA[DLC_W-1:0];
            endcase
        end
        if (TX_BUSY && TX_DONE) begin
            slot_ts[TX_SLOT] <= TS_COUNT;
        end
        if (rx_state == RX_STORE) begin
            slot_id[rx_slot] <= cap_id;
            slot_dlc[rx_slot] <= cap_dlc;
            slot_dlo[rx_slot] <= cap_data[31:0];
            slot_dhi[rx_slot] <= cap_data[63:32];
            slot_ts[rx_slot] <= cap_ts;
        end
    end

    // Configuration registers
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            ier <= '0;
            shared_mode <= 1'b0;
            mask <= MASK_RST;
            ext_sel <= EXT_RST;
        end else if (REG_WR) begin
            if (REG_ADDR == ADR_IER) begin
                ier <= REG_WDATA[NS-1:0];
            end
            if (REG_ADDR == ADR_MODE) begin
                shared_mode <= REG_WDATA[MODE_SHARED];
            end
            if (REG_ADDR == ADR_MASK) begin
                mask <= REG_WDATA[ID_W-1:0];
            end
            if (REG_ADDR == ADR_EXT) begin
                ext_sel <= REG_WDATA[NS-1:0];
            end
        end
    end

    // Slot interrupt status: write one to clear, set wins
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            isr <= '0;
            SLOT_IRQ <= 1'b0;
        end else begin
            logic [NS-1:0] v;
            v = isr;
            if (REG_WR && REG_ADDR == ADR_ISR) begin
                v = v & ~REG_WDATA[NS-1:0];
            end
            if (TX_BUSY && TX_DONE) begin
                v[TX_SLOT] = 1'b1;
            end
            if (rx_state == RX_FIN) begin
                v[rx_slot] = 1'b1;
            end
            isr <= v;
            SLOT_IRQ <= |(v & ier);
        end
    end

    // Transmit handoff to the frame engine
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            TX_BUSY <= 1'b0;
            TX_START <= 1'b0;
            TX_SLOT <= '0;
            TX_REMOTE <= 1'b0;
            TX_ID <= '0;
            TX_EXT <= 1'b0;
            TX_DLC <= '0;
        end else begin
            TX_START <= tx_go;
            if (tx_go) begin
                TX_BUSY <= 1'b1;
                TX_SLOT <= tx_pick;
                TX_REMOTE <= ra[tx_pick];
                TX_ID <= slot_id[tx_pick];
                TX_EXT <= ext_sel[tx_pick];
                TX_DLC <= slot_dlc[tx_pick];
            end else if (tx_end) begin
                TX_BUSY <= 1'b0;
            end
        end
    end

    // Read data, valid only in the cycle after the read strobe
    always_comb begin
        next_rdata = '0;
        if (REG_ADDR[7:4] == ADR_CTL_PAGE) begin
            next_rdata[CB_TR] = tr[wr_slot];
            next_rdata[CB_RR] = rr[wr_slot];
            next_rdata[CB_RM] = rm[wr_slot];
            next_rdata[CB_ACT] = act[wr_slot];
            next_rdata[CB_RA] = ra[wr_slot];
            next_rdata[CB_OVF] = ovf[wr_slot];
            next_rdata[CB_DONE] = done[wr_slot];
        end else if (REG_ADDR[7:6] == ADR_MSG_PAGE) begin
            unique case (msg_fld)
                MSG_ID: next_rdata[ID_W-1:0] = slot_id[msg_slot];
                MSG_DLO: next_rdata = slot_dlo[msg_slot];
                MSG_DHI: next_rdata = slot_dhi[msg_slot];
                MSG_TSD: begin
                    next_rdata[DLC_W-1:0] = slot_dlc[msg_slot];
                    next_rdata[MSG_TS_LSB +: TSW] = slot_ts[msg_slot];
                end
            endcase
        end else if (REG_ADDR == ADR_ISR) begin
            next_rdata[NS-1:0] = isr;
        end else if (REG_ADDR == ADR_IER) begin
            next_rdata[NS-1:0] = ier;
        end else if (REG_ADDR == ADR_MODE) begin
            next_rdata[MODE_SHARED] = shared_mode;
        end else if (REG_ADDR == ADR_MASK) begin
            next_rdata[ID_W-1:0] = mask;
        end else if (REG_ADDR == ADR_EXT) begin
            next_rdata[NS-1:0] = ext_sel;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            REG_RDATA <= '0;
        end else if (REG_RD) begin
            REG_RDATA <= next_rdata;
        end else begin
            REG_RDATA <= '0;
        end
    end
endmodule
`default_nettype wire
